// File: hw/qmou_defines.vh
// Constants of the quadrature, marker and output unit
`ifndef QMOU_DEFINES_VH
`define QMOU_DEFINES_VH

// ==========================================================
// Timing
`define QMOU_CLK_HZ 25'd20000000
`define QMOU_MARKER_SAMPLE_US 50
`define QMOU_MARKER_SAMPLE_CYC (`QMOU_MARKER_SAMPLE_US * 20)
`define QMOU_DUTY_FULL 15'd32000

// ==========================================================
// Register byte addresses
`define QMOU_ADDR_CTRL 6'h00
`define QMOU_ADDR_LADDER 6'h04
`define QMOU_ADDR_CPR1 6'h08
`define QMOU_ADDR_CPR2 6'h0c
`define QMOU_ADDR_PRESET1 6'h10
`define QMOU_ADDR_PRESET2 6'h14
`define QMOU_ADDR_DUTY1 6'h18
`define QMOU_ADDR_FREQ1 6'h1c
`define QMOU_ADDR_DUTY2 6'h20
`define QMOU_ADDR_FREQ2 6'h24
`define QMOU_ADDR_SDUTY1 6'h28
`define QMOU_ADDR_SFREQ1 6'h2c
`define QMOU_ADDR_SDUTY2 6'h30
`define QMOU_ADDR_SFREQ2 6'h34
`define QMOU_ADDR_ACC1 6'h38
`define QMOU_ADDR_ACC2 6'h3c

// ==========================================================
// Control register fields
`define QMOU_CTRL_W 18
`define QMOU_CTRL_RESET 18'h00000
`define QMOU_C_QUAD1_EN 0
`define QMOU_C_QUAD1_INV 1
`define QMOU_C_QUAD2_EN 2
`define QMOU_C_QUAD2_INV 3
`define QMOU_C_MARKER_EN 4
`define QMOU_C_MMODE_LO 5
`define QMOU_C_MMODE_HI 8
`define QMOU_C_OUT1_LO 9
`define QMOU_C_OUT1_HI 10
`define QMOU_C_OUT2_LO 11
`define QMOU_C_OUT2_HI 12
`define QMOU_C_DOUT1 13
`define QMOU_C_DOUT2 14
`define QMOU_C_STOP 15
`define QMOU_C_HOLD1 16
`define QMOU_C_HOLD2 17

// ==========================================================
// Marker modes (bit3 sync, bit2 low level, bit1 input 2, bit0 falling)
`define QMOU_MM_ASYNC_RISE 4'h0
`define QMOU_MM_ASYNC_FALL 4'h1
`define QMOU_MM_ASYNC_BOTH 4'h2
`define QMOU_MM_SYNC 3
`define QMOU_MM_LOW 2
`define QMOU_MM_IN2 1
`define QMOU_MM_FALLNAME 0

// ==========================================================
// Output channel modes
`define QMOU_OM_NORMAL 2'h0
`define QMOU_OM_PWM 2'h1
`define QMOU_OM_COMPARE 2'h2

`endif

// File: hw/qmou_pwm.v
// One PWM generator channel with run and stop settings
`timescale 1ns/100ps
`include "qmou_defines.vh"

module qmou_pwm (
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Run settings
	input wire [31:0] run_duty,
	input wire [31:0] run_freq,
	// Stop settings
	input wire [31:0] stop_duty,
	input wire [31:0] stop_freq,
	input wire stop_mode,
	input wire stop_hold,
	// Waveform
	output reg pwm_out
);

	// ==========================================================
	// Setting selection
	// Ticks of the timebase per duty step
	localparam [24:0] TICKS_FULL = `QMOU_CLK_HZ / `QMOU_DUTY_FULL;
	localparam [9:0] TICKS = TICKS_FULL[9:0];
	wire use_stop = stop_mode & ~stop_hold;
	wire [31:0] duty = use_stop ? stop_duty : run_duty;
	wire [31:0] freq = use_stop ? stop_freq : run_freq;
	// Zero in either word keeps the output low, except in stop mode with hold set, where it keeps its last state
	wire live = (duty != 32'h0) && (freq != 32'h0);
	// Clamp so the phase step stays below one full turn
	wire [24:0] freq_c = (freq >= {7'h0, `QMOU_CLK_HZ}) ?
		(`QMOU_CLK_HZ - 25'h1) : freq[24:0];
	wire [14:0] duty_c = (duty >= {17'h0, `QMOU_DUTY_FULL}) ?
		`QMOU_DUTY_FULL : duty[14:0];
	// High-time threshold on the phase scale
	wire [24:0] thr = duty_c * TICKS;

	// ==========================================================
	// Phase accumulator timebase
	reg [24:0] phase_reg; // Position within one period
	wire [25:0] sum = {1'b0, phase_reg} + {1'b0, freq_c};
	wire [25:0] wrap = sum - {1'b0, `QMOU_CLK_HZ};
	wire [24:0] phase_next = (sum >= {1'b0, `QMOU_CLK_HZ}) ?
		wrap[24:0] : sum[24:0];

	// Period is the reciprocal of the frequency word
	// timebase divided by settings
	always @(posedge core_clk) begin
		if (!rstn) begin
			phase_reg <= 25'h0;
			pwm_out <= 1'b0;
		end else if (stop_mode && stop_hold) begin
			phase_reg <= phase_reg;
		end else if (!live) begin
			phase_reg <= 25'h0;
			pwm_out <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			if (duty_c == `QMOU_DUTY_FULL)
				pwm_out <= 1'b1;
			else
				pwm_out <= (phase_reg < thr);
		end
	end

endmodule

// File: hw/qmou_top.v
// Quadrature counters with marker, compare and PWM outputs
`timescale 1ns/100ps
`include "qmou_defines.vh"

module qmou_top (
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Register port
	input wire [5:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Encoder pins
	input wire counter_input_1,
	input wire counter_input_2,
	input wire counter_input_3,
	input wire counter_input_4,
	// Dedicated outputs
	output reg output_channel_1,
	output reg output_channel_2
);

	// ==========================================================
	// Functions
	// Quadrature step: {moved, up}; only one input may change
	function [1:0] qmou_step;
		input a_old;
		input b_old;
		input a_new;
		input b_new;
		input invert;
		begin
			qmou_step = {(a_old ^ a_new) ^ (b_old ^ b_new),
				a_new ^ b_old ^ invert};
		end
	endfunction

	// Next count with wrap at counts per revolution
	function [31:0] qmou_count;
		input [31:0] acc;
		input [31:0] counts_per_revolution;
		input up;
		begin
			if (up)
				qmou_count = ((counts_per_revolution != 32'h0) && (acc == counts_per_revolution - 32'h1)) ?
					32'h0 : acc + 32'h1;
			else
				qmou_count = (acc == 32'h0) ? counts_per_revolution - 32'h1 : acc - 32'h1;
		end
	endfunction

	// ==========================================================
	// Register storage
	reg [`QMOU_CTRL_W-1:0] ctrl_reg; // Modes and loose control bits
	reg [3:0] ladder_reg; // Clear and set levels
	reg [31:0] cpr1_reg; // Counts per revolution, counter 1
	reg [31:0] cpr2_reg; // Counts per revolution, counter 3
	reg [31:0] counter1_preset_reg;
	reg [31:0] counter2_preset_reg;
	reg [31:0] duty1_reg;
	reg [31:0] freq1_reg;
	reg [31:0] duty2_reg;
	reg [31:0] freq2_reg;
	reg [31:0] sduty1_reg; // Stop-mode duty, channel 1
	reg [31:0] sfreq1_reg;
	reg [31:0] sduty2_reg;
	reg [31:0] sfreq2_reg;
	// Accumulators
	reg [31:0] counter1_accumulator_reg;
	reg [31:0] counter2_accumulator_reg;
	reg [31:0] counter3_accumulator_reg;
	reg [31:0] counter4_accumulator_reg;
	// Last seen direction; no register reads it out
	reg dir1_reg;
	reg dir2_reg;

	// Control field views
	wire quad1_en = ctrl_reg[`QMOU_C_QUAD1_EN];
	wire [3:0] mmode = ctrl_reg[`QMOU_C_MMODE_HI:`QMOU_C_MMODE_LO];
	wire marker_on = quad1_en & ctrl_reg[`QMOU_C_MARKER_EN];
	// Input 3 belongs to the marker, so counter 3 quad is off
	wire quad2_en = ctrl_reg[`QMOU_C_QUAD2_EN] & ~marker_on;
	wire [1:0] out1_mode = ctrl_reg[`QMOU_C_OUT1_HI:`QMOU_C_OUT1_LO];
	wire [1:0] out2_mode = ctrl_reg[`QMOU_C_OUT2_HI:`QMOU_C_OUT2_LO];

	// ==========================================================
	// Pin synchronisers
	wire [3:0] pins = {counter_input_4, counter_input_3,
		counter_input_2, counter_input_1};
	reg [3:0] meta_reg; // First stage, read only by second stage
	reg [3:0] sync_reg; // Safe level
	reg [3:0] prev_reg; // Level one cycle earlier
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
			// Two flops per pin, then an edge history flop
			always @(posedge core_clk) begin
				if (!rstn) begin
					meta_reg[gi] <= 1'b0;
					sync_reg[gi] <= 1'b0;
					prev_reg[gi] <= 1'b0;
				end else begin
					meta_reg[gi] <= pins[gi];
					sync_reg[gi] <= meta_reg[gi];
					prev_reg[gi] <= sync_reg[gi];
				end
			end
		end
	endgenerate

	// Edge strobes of the settled levels
	wire [3:0] rise = sync_reg & ~prev_reg;
	wire [3:0] fall = ~sync_reg & prev_reg;

	// ==========================================================
	// Quadrature decode
	// every edge counts, lead decides
	wire [1:0] step1 = qmou_step(prev_reg[0], prev_reg[1], sync_reg[0],
		sync_reg[1], ctrl_reg[`QMOU_C_QUAD1_INV]);
	wire [1:0] step2 = qmou_step(prev_reg[2], prev_reg[3], sync_reg[2],
		sync_reg[3], ctrl_reg[`QMOU_C_QUAD2_INV]);

	// ==========================================================
	// Marker decision
	// Marker level travels the same two flops as A and B, so it is
	// sampled in the very cycle the quadrature edge is seen, far
	// inside the sampling window.
	reg marker_hit; // Load requested this cycle
	reg marker_preset; // Load cpr minus one rather than zero
	reg sel_rise;
	reg sel_fall;
	reg level_ok;
	always @* begin
		marker_hit = 1'b0;
		marker_preset = 1'b0;
		sel_rise = mmode[`QMOU_MM_IN2] ? rise[1] : rise[0];
		sel_fall = mmode[`QMOU_MM_IN2] ? fall[1] : fall[0];
		level_ok = sync_reg[2] ^ mmode[`QMOU_MM_LOW];
		if (!marker_on) begin
			marker_hit = 1'b0;
		end else if (!mmode[`QMOU_MM_SYNC]) begin
			case (mmode)
				`QMOU_MM_ASYNC_RISE: marker_hit = rise[2];
				`QMOU_MM_ASYNC_FALL: marker_hit = fall[2];
				`QMOU_MM_ASYNC_BOTH: marker_hit = rise[2] | fall[2];
				default: marker_hit = 1'b0;
			endcase
		end else if (step1[1] && level_ok) begin
			if (sel_rise && step1[0]) begin
				marker_hit = 1'b1;
				marker_preset = mmode[`QMOU_MM_FALLNAME];
			end else if (sel_fall && !step1[0]) begin
				marker_hit = 1'b1;
				marker_preset = ~mmode[`QMOU_MM_FALLNAME];
			end
		end
	end

	// ==========================================================
	// Register writes
	// Software writes only; counters live in their own process
	always @(posedge core_clk) begin
		if (!rstn) begin
			ctrl_reg <= `QMOU_CTRL_RESET;
			ladder_reg <= 4'h0;
			cpr1_reg <= 32'h0;
			cpr2_reg <= 32'h0;
			counter1_preset_reg <= 32'h0;
			counter2_preset_reg <= 32'h0;
			duty1_reg <= 32'h0;
			freq1_reg <= 32'h0;
			duty2_reg <= 32'h0;
			freq2_reg <= 32'h0;
			sduty1_reg <= 32'h0;
			sfreq1_reg <= 32'h0;
			sduty2_reg <= 32'h0;
			sfreq2_reg <= 32'h0;
		end else if (reg_wr) begin
			case (reg_addr)
				`QMOU_ADDR_CTRL: ctrl_reg <= reg_wdata[`QMOU_CTRL_W-1:0];
				`QMOU_ADDR_LADDER: ladder_reg <= reg_wdata[3:0];
				`QMOU_ADDR_CPR1: cpr1_reg <= reg_wdata;
				`QMOU_ADDR_CPR2: cpr2_reg <= reg_wdata;
				`QMOU_ADDR_PRESET1: counter1_preset_reg <= reg_wdata;
				`QMOU_ADDR_PRESET2: counter2_preset_reg <= reg_wdata;
				`QMOU_ADDR_DUTY1: duty1_reg <= reg_wdata;
				`QMOU_ADDR_FREQ1: freq1_reg <= reg_wdata;
				`QMOU_ADDR_DUTY2: duty2_reg <= reg_wdata;
				`QMOU_ADDR_FREQ2: freq2_reg <= reg_wdata;
				`QMOU_ADDR_SDUTY1: sduty1_reg <= reg_wdata;
				`QMOU_ADDR_SFREQ1: sfreq1_reg <= reg_wdata;
				`QMOU_ADDR_SDUTY2: sduty2_reg <= reg_wdata;
				`QMOU_ADDR_SFREQ2: sfreq2_reg <= reg_wdata;
				// Read-only and unmapped writes are dropped
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// ==========================================================
	// Counter 1: quadrature with marker, else totalize input 1
	// Ladder levels hold the count at zero, or in quadrature at cpr minus one, while asserted
	always @(posedge core_clk) begin
		if (!rstn) begin
			counter1_accumulator_reg <= 32'h0;
			dir1_reg <= 1'b0;
		end else if (ladder_reg[0]) begin
			counter1_accumulator_reg <= 32'h0;
		end else if (quad1_en && ladder_reg[1]) begin
			counter1_accumulator_reg <= cpr1_reg - 32'h1;
		end else if (marker_hit) begin
			counter1_accumulator_reg <= marker_preset ?
				cpr1_reg - 32'h1 : 32'h0;
			dir1_reg <= step1[0];
		end else if (quad1_en && step1[1]) begin
			counter1_accumulator_reg <= qmou_count(
				counter1_accumulator_reg, cpr1_reg, step1[0]);
			dir1_reg <= step1[0];
		end else if (!quad1_en && rise[0]) begin
			counter1_accumulator_reg <= qmou_count(
				counter1_accumulator_reg, cpr1_reg, 1'b1);
		end
	end

	// ==========================================================
	// Counter 2: totalize input 2 while it is not quadrature B
	always @(posedge core_clk) begin
		if (!rstn)
			counter2_accumulator_reg <= 32'h0;
		else if (!quad1_en && ladder_reg[1])
			counter2_accumulator_reg <= 32'h0;
		else if (!quad1_en && rise[1])
			counter2_accumulator_reg <= counter2_accumulator_reg + 32'h1;
	end

	// ==========================================================
	// Counter 3: second quadrature pair, else totalize input 3 unless it carries the marker
	always @(posedge core_clk) begin
		if (!rstn) begin
			counter3_accumulator_reg <= 32'h0;
			dir2_reg <= 1'b0;
		end else if (ladder_reg[2]) begin
			counter3_accumulator_reg <= 32'h0;
		end else if (quad2_en && ladder_reg[3]) begin
			counter3_accumulator_reg <= cpr2_reg - 32'h1;
		end else if (quad2_en && step2[1]) begin
			counter3_accumulator_reg <= qmou_count(
				counter3_accumulator_reg, cpr2_reg, step2[0]);
			dir2_reg <= step2[0];
		end else if (!quad2_en && !marker_on && rise[2]) begin
			counter3_accumulator_reg <= qmou_count(
				counter3_accumulator_reg, cpr2_reg, 1'b1);
		end
	end

	// ==========================================================
	// Counter 4: totalize input 4 while not quadrature B
	always @(posedge core_clk) begin
		if (!rstn)
			counter4_accumulator_reg <= 32'h0;
		else if (!quad2_en && ladder_reg[3])
			counter4_accumulator_reg <= 32'h0;
		else if (!quad2_en && rise[3])
			counter4_accumulator_reg <= counter4_accumulator_reg + 32'h1;
	end

	// ==========================================================
	// PWM generators
	wire pwm1;
	wire pwm2;
	qmou_pwm u_pwm1 (
		.core_clk(core_clk),
		.rstn(rstn),
		.run_duty(duty1_reg),
		.run_freq(freq1_reg),
		.stop_duty(sduty1_reg),
		.stop_freq(sfreq1_reg),
		.stop_mode(ctrl_reg[`QMOU_C_STOP]),
		.stop_hold(ctrl_reg[`QMOU_C_HOLD1]),
		.pwm_out(pwm1)
	);
	qmou_pwm u_pwm2 (
		.core_clk(core_clk),
		.rstn(rstn),
		.run_duty(duty2_reg),
		.run_freq(freq2_reg),
		.stop_duty(sduty2_reg),
		.stop_freq(sfreq2_reg),
		.stop_mode(ctrl_reg[`QMOU_C_STOP]),
		.stop_hold(ctrl_reg[`QMOU_C_HOLD2]),
		.pwm_out(pwm2)
	);

	// ==========================================================
	// Compare results
	// high at or above a nonzero preset; low while preset is zero
	wire cmp1 = (counter1_preset_reg != 32'h0) &&
		(counter1_accumulator_reg >= counter1_preset_reg);
	wire cmp2 = (counter2_preset_reg != 32'h0) &&
		(counter2_accumulator_reg >= counter2_preset_reg);

	// ==========================================================
	// Output channel selection, registered at the pin
	// Adds one cycle after the PWM flop; glitch free at the pin
	always @(posedge core_clk) begin
		if (!rstn) begin
			output_channel_1 <= 1'b0;
			output_channel_2 <= 1'b0;
		end else begin
			case (out1_mode)
				`QMOU_OM_NORMAL: output_channel_1 <= ctrl_reg[`QMOU_C_DOUT1];
				`QMOU_OM_PWM: output_channel_1 <= pwm1;
				`QMOU_OM_COMPARE: output_channel_1 <= cmp1;
				default: output_channel_1 <= 1'b0;
			endcase
			case (out2_mode)
				`QMOU_OM_NORMAL: output_channel_2 <= ctrl_reg[`QMOU_C_DOUT2];
				`QMOU_OM_PWM: output_channel_2 <= pwm2;
				`QMOU_OM_COMPARE: output_channel_2 <= cmp2;
				default: output_channel_2 <= 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Register reads, data valid the cycle after the strobe
	always @(posedge core_clk) begin
		if (!rstn) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				`QMOU_ADDR_CTRL: reg_rdata <= {14'h0, ctrl_reg};
				`QMOU_ADDR_LADDER: reg_rdata <= {28'h0, ladder_reg};
				`QMOU_ADDR_CPR1: reg_rdata <= cpr1_reg;
				`QMOU_ADDR_CPR2: reg_rdata <= cpr2_reg;
				`QMOU_ADDR_PRESET1: reg_rdata <= counter1_preset_reg;
				`QMOU_ADDR_PRESET2: reg_rdata <= counter2_preset_reg;
				`QMOU_ADDR_DUTY1: reg_rdata <= duty1_reg;
				`QMOU_ADDR_FREQ1: reg_rdata <= freq1_reg;
				`QMOU_ADDR_DUTY2: reg_rdata <= duty2_reg;
				`QMOU_ADDR_FREQ2: reg_rdata <= freq2_reg;
				`QMOU_ADDR_SDUTY1: reg_rdata <= sduty1_reg;
				`QMOU_ADDR_SFREQ1: reg_rdata <= sfreq1_reg;
				`QMOU_ADDR_SDUTY2: reg_rdata <= sduty2_reg;
				`QMOU_ADDR_SFREQ2: reg_rdata <= sfreq2_reg;
				`QMOU_ADDR_ACC1: reg_rdata <= counter1_accumulator_reg;
				`QMOU_ADDR_ACC2: reg_rdata <= counter2_accumulator_reg;
				// Unmapped addresses read as zero
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

endmodule

// File: test/qmou_encoder.sv
// Encoder model: quadrature pair and marker pin
`timescale 1ns/100ps

module qmou_encoder (
	// Pacing clock
	input wire core_clk,
	// Encoder pins
	output reg enc_a,
	output reg enc_b,
	output reg enc_mark
);
	initial begin
		enc_a = 1'b0;
		enc_b = 1'b0;
		enc_mark = 1'b0;
	end

	// Gray order, one pin per step
	function [1:0] nxt(input [1:0] s, input up);
		case (s)
		2'b00: nxt = up ? 2'b10 : 2'b01;
		2'b10: nxt = up ? 2'b11 : 2'b00;
		2'b11: nxt = up ? 2'b01 : 2'b10;
		default: nxt = up ? 2'b00 : 2'b11;
		endcase
	endfunction

	// marker settles before the edge and stays at its level after it
	task step(input up, input mk);
		begin
			enc_mark <= mk;
			repeat (2) @(posedge core_clk);
			{enc_a, enc_b} <= nxt({enc_a, enc_b}, up);
			repeat (6) @(posedge core_clk);
		end
	endtask

	// Marker level change with no quadrature edge
	task mark(input v);
		begin
			enc_mark <= v;
			repeat (6) @(posedge core_clk);
		end
	endtask
endmodule

// File: test/qmou_properties.sv
// Checker of output and register port relations
`timescale 1ns/100ps
`include "qmou_defines.vh"

module qmou_checker (
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Register port
	input wire [5:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Encoder pins
	input wire counter_input_1,
	input wire counter_input_2,
	input wire counter_input_3,
	input wire counter_input_4,
	// Outputs
	input wire output_channel_1,
	input wire output_channel_2
);
	// ==========================================================
	// Shadow copies of written settings
	reg [17:0] ctl_reg; // Control word
	reg [31:0] duty_reg; // Run duty, channel 1
	reg [31:0] freq_reg; // Run frequency, channel 1
	reg [31:0] sduty_reg; // Stop duty, channel 1
	reg [31:0] sfreq_reg; // Stop frequency, channel 1
	reg [31:0] pre_reg; // Preset, counter 1
	reg [31:0] duty2_reg; // Run duty, channel 2
	reg [3:0] age_reg; // Cycles since a write, saturating
	// Outputs lag settings, so judge only once writes have settled
	wire settled = (age_reg > 4'h4);
	wire [1:0] m1 = ctl_reg[10:9];
	wire [1:0] m2 = ctl_reg[12:11];

	// Follow every write the way the block decodes it
	always @(posedge core_clk) begin
		if (!rstn) begin
			ctl_reg <= 18'h0;
			duty_reg <= 32'h0;
			freq_reg <= 32'h0;
			sduty_reg <= 32'h0;
			sfreq_reg <= 32'h0;
			pre_reg <= 32'h0;
			duty2_reg <= 32'h0;
			age_reg <= 4'h0;
		end else if (reg_wr) begin
			age_reg <= 4'h0;
			case (reg_addr)
			`QMOU_ADDR_CTRL: ctl_reg <= reg_wdata[17:0];
			`QMOU_ADDR_DUTY1: duty_reg <= reg_wdata;
			`QMOU_ADDR_FREQ1: freq_reg <= reg_wdata;
			`QMOU_ADDR_SDUTY1: sduty_reg <= reg_wdata;
			`QMOU_ADDR_SFREQ1: sfreq_reg <= reg_wdata;
			`QMOU_ADDR_PRESET1: pre_reg <= reg_wdata;
			`QMOU_ADDR_DUTY2: duty2_reg <= reg_wdata;
			default: ;
			endcase
		end else if (age_reg != 4'hf) begin
			age_reg <= age_reg + 4'h1;
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Channel 1 generating, run or stop
	sequence s_run1;
		settled && m1 == `QMOU_OM_PWM && !ctl_reg[15];
	endsequence
	sequence s_stop1;
		settled && m1 == `QMOU_OM_PWM && ctl_reg[15];
	endsequence

	a_normal_out1:
	assert property (settled && m1 == `QMOU_OM_NORMAL
		|-> output_channel_1 == ctl_reg[13]) else $error("out1 off bit");
	a_normal_out2:
	assert property (settled && m2 == `QMOU_OM_NORMAL
		|-> output_channel_2 == ctl_reg[14]) else $error("out2 off bit");
	a_pwm_unloaded:
	assert property (s_run1 ##0 (duty_reg == 0 || freq_reg == 0)
		|-> !output_channel_1) else $error("pwm1 high unloaded");
	a_pwm_full_on:
	assert property (s_run1 ##0 (duty_reg >= 32000 && freq_reg != 0)
		|-> output_channel_1) else $error("pwm1 not full on");
	a_stop_zero_low:
	assert property (s_stop1 ##0 (!ctl_reg[16] && (sduty_reg == 0
		|| sfreq_reg == 0)) |-> !output_channel_1)
		else $error("pwm1 high in stop");
	a_stop_hold_last:
	assert property (s_stop1 ##0 ctl_reg[16] |=> $stable(output_channel_1))
		else $error("pwm1 moved in hold");
	a_preset_zero_low:
	assert property (settled && m1 == `QMOU_OM_COMPARE && pre_reg == 0
		|-> !output_channel_1) else $error("compare high at zero");
	a_pwm2_off:
	assert property (settled && m2 == `QMOU_OM_PWM && !ctl_reg[15]
		&& duty2_reg == 0 |-> !output_channel_2)
		else $error("pwm2 high at zero");
endmodule

// File: test/qmou_tb.sv
// Testbench of the quadrature, marker and output unit
`timescale 1ns/100ps
`include "qmou_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	error_cnt++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module testbench;
	// ==========================================================
	// Stimulus and observation
	reg core_clk = 1'b0;
	reg rstn = 1'b0; // Held low through 8 cycles
	reg [5:0] reg_addr = 6'h00;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	wire [31:0] reg_rdata;
	wire enc_a, enc_b, enc_m;
	wire out1, out2;
	integer error_cnt = 0, checks_done = 0, cyc = 0, h1, h2, i, j;
	reg [31:0] got, v;

	qmou_top dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .counter_input_1(enc_a),
		.counter_input_2(enc_b), .counter_input_3(enc_m),
		.counter_input_4(1'b0), .output_channel_1(out1),
		.output_channel_2(out2));
	qmou_encoder enc (.core_clk(core_clk), .enc_a(enc_a), .enc_b(enc_b),
		.enc_mark(enc_m));

	// 50 ns clock
	initial forever #25 core_clk = ~core_clk;
	// Cut a hang short; tests need about 9000 cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			report_and_stop;
		end
	end

	// ==========================================================
	// Bus and measuring tasks
	task wr(input [5:0] a, input [31:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge core_clk);
			reg_wr <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	// Read data stand only in the cycle after the strobe
	task rc(input [5:0] a, input [31:0] e);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			#1 got = reg_rdata;
			`CHK(got, e)
			@(posedge core_clk);
		end
	endtask
	task clr;
		begin
			wr(`QMOU_ADDR_LADDER, 32'h1);
			wr(`QMOU_ADDR_LADDER, 32'h0);
		end
	endtask
	// High cycles of both outputs, after the output lag
	task meas(input integer n);
		begin
			h1 = 0;
			h2 = 0;
			repeat (4) @(posedge core_clk);
			repeat (n) begin
				@(posedge core_clk);
				h1 += out1;
				h2 += out2;
			end
		end
	endtask
	// Idle steps, then one marked edge on the chosen input
	task sync_run(input [3:0] m, input up);
		reg [1:0] s;
		reg [1:0] n;
		reg hit;
		integer k;
		begin
			wr(`QMOU_ADDR_CTRL, 32'h11 | ({28'h0, m} << 5));
			clr();
			repeat (10) enc.step(1'b1, m[2]);
			hit = 1'b0;
			for (k = 0; k < 4 && !hit; k++) begin
				s = {enc.enc_a, enc.enc_b};
				n = enc.nxt(s, up);
				hit = up ? (!s[!m[1]] && n[!m[1]]) : (s[!m[1]] && !n[!m[1]]);
				enc.step(up, hit ? !m[2] : m[2]);
			end
			rc(`QMOU_ADDR_ACC1, (up != m[0]) ? 32'd0 : 32'd99);
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", checks_done, error_cnt);
			if (error_cnt == 0 && checks_done > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge core_clk);
		for (i = 0; i < 16; i++) rc(6'(i * 4), 32'h0);
		wr(`QMOU_ADDR_PRESET1, 32'ha5c30f96);
		rc(`QMOU_ADDR_PRESET1, 32'ha5c30f96); // preset kept
		wr(`QMOU_ADDR_ACC1, 32'h1234);
		rc(`QMOU_ADDR_ACC1, 32'h0); // no edges seen
		rc(6'h02, 32'h0);
		$display("test registers done");
		// Counting and wrap at both ends
		wr(`QMOU_ADDR_CPR1, 32'd100);
		wr(`QMOU_ADDR_CTRL, 32'h1);
		clr();
		repeat (4) enc.step(1'b1, 1'b0);
		rc(`QMOU_ADDR_ACC1, 32'd4); // four per cycle
		wr(`QMOU_ADDR_LADDER, 32'h2);
		rc(`QMOU_ADDR_ACC1, 32'd99);
		wr(`QMOU_ADDR_LADDER, 32'h0);
		enc.step(1'b1, 1'b0);
		rc(`QMOU_ADDR_ACC1, 32'd0); // up wrap
		enc.step(1'b0, 1'b0);
		rc(`QMOU_ADDR_ACC1, 32'd99); // down wrap
		wr(`QMOU_ADDR_CPR1, 32'd0);
		clr();
		enc.step(1'b0, 1'b0);
		rc(`QMOU_ADDR_ACC1, 32'hffffffff); // full range
		wr(`QMOU_ADDR_CPR1, 32'd100);
		$display("test counting done");
		// Asynchronous marker modes; last pass has marker disabled
		for (i = 0; i < 4; i++) begin
			clr();
			wr(`QMOU_ADDR_CTRL, i == 3 ? 32'h1 : 32'h11 | (i << 5));
			repeat (3) enc.step(1'b1, 1'b0);
			enc.mark(1'b1);
			v = (i == 0 || i == 2) ? 32'd0 : 32'd3;
			rc(`QMOU_ADDR_ACC1, v); // marker rise
			repeat (2) enc.step(1'b1, 1'b1);
			v = (i == 1 || i == 2) ? 32'd0 : v + 32'd2;
			enc.mark(1'b0);
			rc(`QMOU_ADDR_ACC1, v); // marker fall
		end
		// Synchronous modes, both directions
		for (i = 8; i < 16; i++) begin
			for (j = 0; j < 2; j++) sync_run(i[3:0], j[0]);
		end
		$display("test marker done");
		// Normal outputs
		wr(`QMOU_ADDR_CTRL, 32'h6000);
		meas(10);
		`CHK(h1 + h2, 20) // both follow bits
		wr(`QMOU_ADDR_CTRL, 32'h2000);
		meas(10);
		`CHK(h2, 0) // second cleared
		// Compare output
		wr(`QMOU_ADDR_CTRL, 32'h401);
		wr(`QMOU_ADDR_PRESET1, 32'd5);
		clr();
		repeat (4) enc.step(1'b1, 1'b0);
		meas(4);
		`CHK(h1, 0) // below preset
		for (i = 0; i < 2; i++) begin
			enc.step(1'b1, 1'b0);
			meas(4);
			`CHK(h1, 4) // at or above
		end
		wr(`QMOU_ADDR_PRESET1, 32'd0);
		meas(4);
		`CHK(h1, 0) // preset zero
		// Counter 2 totalizes input 2 and drives output 2
		wr(`QMOU_ADDR_PRESET2, 32'd1);
		wr(`QMOU_ADDR_CTRL, 32'h1000);
		meas(4);
		`CHK(h2, 0) // below preset
		repeat (4) enc.step(1'b1, 1'b0);
		rc(`QMOU_ADDR_ACC2, 32'd1); // one rise of input 2
		meas(4);
		`CHK(h2, 4) // at or above
		$display("test outputs done");
		// PWM run settings
		wr(`QMOU_ADDR_CTRL, 32'ha00);
		wr(`QMOU_ADDR_DUTY1, 32'd16000);
		meas(200);
		`CHK(h1 + h2, 0) // unloaded stays low
		wr(`QMOU_ADDR_FREQ1, 32'd10000);
		wr(`QMOU_ADDR_DUTY2, 32'd8000);
		wr(`QMOU_ADDR_FREQ2, 32'd5000);
		meas(4000);
		`CHK(h1, 2000) // half duty
		`CHK(h2, 1000) // quarter duty
		wr(`QMOU_ADDR_DUTY1, 32'd32000);
		meas(100);
		`CHK(h1, 100) // full on
		wr(`QMOU_ADDR_DUTY1, 32'd0);
		meas(100);
		`CHK(h1, 0) // zero off
		// Stop behaviour
		wr(`QMOU_ADDR_DUTY1, 32'd16000);
		wr(`QMOU_ADDR_SDUTY1, 32'd8000);
		wr(`QMOU_ADDR_SFREQ1, 32'd10000);
		wr(`QMOU_ADDR_CTRL, 32'h8a00);
		meas(2000);
		`CHK(h1, 500) // stop words used
		wr(`QMOU_ADDR_SDUTY1, 32'd0);
		meas(100);
		`CHK(h1, 0) // zero stop word
		wr(`QMOU_ADDR_CTRL, 32'ha00);
		wr(`QMOU_ADDR_CTRL, 32'h18a00);
		meas(200);
		`CHK(h1 == 0 || h1 == 200, 1'b1) // last state held
		$display("test pwm done");
		report_and_stop;
	end
endmodule

bind qmou_top qmou_checker chk (.core_clk(core_clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.counter_input_1(counter_input_1), .counter_input_2(counter_input_2),
	.counter_input_3(counter_input_3), .counter_input_4(counter_input_4),
	.output_channel_1(output_channel_1),
	.output_channel_2(output_channel_2));
